// ===== design/uhfa_regs.sv
// What this block does
// - A 1 in bits 0..6 of the enable-set port turns on the seven events.
// - A 1 in bit 8+X of the enable-set port turns on pipe X, X in 0..6.
// - A 1 in bit 24+X of the enable-set port turns on DMA channel X, X in 1..6.
// - Zeros written to set or clear ports change nothing; both read 0.
// - A 1 in an event bit of the enable-clear port turns that event off.
// - A 1 in the pipe X bit of the enable-clear port turns pipe X off.
// - A 1 in the DMA X bit of the enable-clear port turns channel X off.
// - The frame register shows the current frame number in bits 13:3.
// - A written frame number is loaded and numbering goes on from it.
// - Bits 23:16 of the frame register show the top of the length count.
// - The length counter runs at 12 MHz over 12000 counts, 1 ms a frame.
// - The low address register holds pipes 0..3 at byte lanes 0..3.
// - The high address register holds pipes 4..6; its top byte is zero.
// - A bus reset request clears every pipe address to zero.
// - The enables read back in the enable view register, same bits.
`timescale 1ns/1ps
module uhfa_regs
   import uhfa_pkg::*;
#(
   parameter int unsigned FRAME_LEN = FRAME_LEN_DEF
)(
   input  wire logic                          ref_clk_in,
   input  wire logic                          rst_in,
   input  wire logic                          hsel_in,
   input  wire logic [31:0]                   haddr_in,
   input  wire logic [1:0]                    htrans_in,
   input  wire logic                          hwrite_in,
   input  wire logic [2:0]                    hsize_in,
   input  wire logic [31:0]                   hwdata_in,
   input  wire logic                          hready_in,
   output logic      [31:0]                   hrdata_out,
   output logic                               hreadyout_out,
   output logic                               hresp_out,
   input  wire logic [31:0]                   irq_flags_in,
   input  wire logic                          usb_reset_req_in,
   output logic                               irq_out,
   output logic                               host_irq_req_out,
   output logic                               sof_pulse_out,
   output logic      [SOF_COUNT_W-1:0]             sof_count_out,
   output logic      [PIPES-1:0][ADDR_W-1:0]  pipe_dev_addr_out
);

   // Bus slave state.
   uhfa_bus_state_type    state_reg;
   uhfa_bus_state_type    state_next;
   logic [ADDR_DEC_W-1:0] addr_reg;
   logic [ADDR_DEC_W-1:0] addr_next;
   logic                  word_ok_reg;
   logic                  word_ok_next;
   logic [31:0]           hrdata_reg;
   logic [31:0]           hrdata_next;

   // Register state.
   logic [31:0]           en_reg;
   logic [31:0]           en_next;
   logic [STAT_W-1:0]     stat_reg;
   logic [STAT_W-1:0]     stat_next;
   logic [STAT_W-1:0]     mask_reg;
   logic [STAT_W-1:0]     mask_next;
   logic                  irq_reg;
   logic                  irq_next;
   logic                  req_reg;
   logic                  req_next;
   logic                  rst_req_prev_reg;
   logic                  rst_req_prev_next;

   // Decoded strobes and helpers.
   logic                  take;
   logic                  wr_fire;
   logic                  rd_latch;
   logic                  wr_set;
   logic                  wr_clr;
   logic                  wr_frame;
   logic                  wr_low;
   logic                  wr_high;
   logic                  wr_mask;
   logic                  rd_stat;
   logic                  wipe_evt;
   logic [31:0]           set_bits;
   logic [31:0]           clr_bits;
   logic [31:0]           rd_word;
   logic [FCNT_W-1:0]     flen;
   logic                  sof_pulse;
   logic [SOF_COUNT_W-1:0]     sof_count;
   logic [PIPES-1:0]      pipe_wr;
   logic [PIPES-1:0][ADDR_W-1:0] pipe_addr;

   // An address phase is taken only when the slave is selected, the
   // transfer is active and the previous transfer has completed.
   assign take = hsel_in & hready_in & htrans_in[HTRANS_ACT_BIT];

   // Bus sequencer. Writes complete with no wait state. Reads insert one
   // wait state so that the read word is sampled after any write that
   // ran in the cycle before; this keeps write-then-read coherent at the
   // cost of one cycle per read.
   always_comb begin
      state_next   = state_reg;
      addr_next    = addr_reg;
      word_ok_next = word_ok_reg;
      case (state_reg)
         UHFA_IDLE, UHFA_WRITE, UHFA_RD_DONE: begin
            if (take) begin
               addr_next    = haddr_in[ADDR_DEC_W-1:0];
               word_ok_next = (hsize_in == HSIZE_WORD);
               state_next   = hwrite_in ? UHFA_WRITE : UHFA_RD_WAIT;
            end else begin
               state_next = UHFA_IDLE;
            end
         end
         UHFA_RD_WAIT: begin
            state_next = UHFA_RD_DONE;
         end
         default: begin
            state_next = UHFA_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg   <= UHFA_IDLE;
         addr_reg    <= '0;
         word_ok_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         addr_reg    <= addr_next;
         word_ok_reg <= word_ok_next;
      end
   end

   // Data-phase strobes. Narrow accesses are accepted but have no effect.
   always_comb begin
      wr_fire  = (state_reg == UHFA_WRITE) & word_ok_reg;
      rd_latch = (state_reg == UHFA_RD_WAIT);
      wr_set   = wr_fire & (addr_reg == OFS_EN_SET);
      wr_clr   = wr_fire & (addr_reg == OFS_EN_CLEAR);
      wr_frame = wr_fire & (addr_reg == OFS_FRAME);
      wr_low   = wr_fire & (addr_reg == OFS_ADDR_LOW);
      wr_high  = wr_fire & (addr_reg == OFS_ADDR_HIGH);
      wr_mask  = wr_fire & (addr_reg == OFS_MASK);
      rd_stat  = rd_latch & word_ok_reg & (addr_reg == OFS_STATUS);
   end

   // Enable bits. Ones in the set word set, ones in the clear word clear,
   // zeros leave the bit alone; bits outside the map are never stored.
   always_comb begin
      set_bits = wr_set ? (hwdata_in & EN_BITS_MASK) : WORD_ZERO;
      clr_bits = wr_clr ? (hwdata_in & EN_BITS_MASK) : WORD_ZERO;
      en_next  = (en_reg | set_bits) & ~clr_bits;
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         en_reg <= WORD_ZERO;
      end else begin
         en_reg <= en_next;
      end
   end

   // Frame generator: length counter, frame number and frame pulse.
   uhfa_frame_timer #(
      .FRAME_LEN     (FRAME_LEN)
   ) u_frame (
      .ref_clk_in    (ref_clk_in),
      .rst_in        (rst_in),
      .load_in       (wr_frame),
      .load_val_in   (hwdata_in[SOF_COUNT_LSB +: SOF_COUNT_W]),
      .sof_count_out (sof_count),
      .flen_out      (flen),
      .sof_pulse_out (sof_pulse)
   );

   // The wipe event is the rising edge of the reset request, so a long
   // request raises the status bit once while the addresses stay cleared.
   always_comb begin
      rst_req_prev_next = usb_reset_req_in;
      wipe_evt          = usb_reset_req_in & ~rst_req_prev_reg;
   end

   // Pipe address write enables: pipes 0..3 live in the low word.
   always_comb begin
      for (int i = 0; i < PIPES; i++) begin
         pipe_wr[i] = (i < PIPES_LOW) ? wr_low : wr_high;
      end
   end

   // One address field per pipe, each on its own byte lane.
   generate
      for (genvar g = 0; g < PIPES; g++) begin : g_pipe
         localparam int unsigned LANE = (g % PIPES_LOW) * ADDR_STRIDE;
         uhfa_addr_field u_field (
            .ref_clk_in (ref_clk_in),
            .rst_in     (rst_in),
            .wr_en_in   (pipe_wr[g]),
            .wr_data_in (hwdata_in[LANE +: ADDR_W]),
            .wipe_in    (usb_reset_req_in),
            .addr_out   (pipe_addr[g])
         );
      end
   endgenerate

   // Sticky status with read-to-clear. An event in the same cycle as the
   // clearing read survives, so no frame or wipe is ever missed.
   always_comb begin
      stat_next = stat_reg;
      if (rd_stat) begin
         stat_next = '0;
      end
      if (sof_pulse) begin
         stat_next[STAT_SOF_BIT] = 1'b1;
      end
      if (wipe_evt) begin
         stat_next[STAT_WIPE_BIT] = 1'b1;
      end
      mask_next = wr_mask ? hwdata_in[STAT_W-1:0] : mask_reg;
      irq_next  = |(stat_next & mask_next);
      req_next  = |(irq_flags_in & en_next & EN_BITS_MASK);
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         stat_reg         <= '0;
         mask_reg         <= '0;
         irq_reg          <= 1'b0;
         req_reg          <= 1'b0;
         rst_req_prev_reg <= 1'b0;
      end else begin
         stat_reg         <= stat_next;
         mask_reg         <= mask_next;
         irq_reg          <= irq_next;
         req_reg          <= req_next;
         rst_req_prev_reg <= rst_req_prev_next;
      end
   end

   // Read multiplexer. Unmapped offsets and narrow reads return zero.
   always_comb begin
      rd_word = WORD_ZERO;
      case (addr_reg)
         OFS_EN_VIEW: begin
            rd_word = en_reg;
         end
         OFS_EN_SET, OFS_EN_CLEAR: begin
            rd_word = WORD_ZERO;
         end
         OFS_FRAME: begin
            rd_word[SOF_COUNT_LSB +: SOF_COUNT_W] = sof_count;
            rd_word[FLEN_LSB +: FLEN_W] = flen[FCNT_W-1 -: FLEN_W];
         end
         OFS_ADDR_LOW: begin
            for (int i = 0; i < PIPES_LOW; i++) begin
               rd_word[i*ADDR_STRIDE +: ADDR_W] = pipe_addr[i];
            end
         end
         OFS_ADDR_HIGH: begin
            for (int i = PIPES_LOW; i < PIPES; i++) begin
               rd_word[(i-PIPES_LOW)*ADDR_STRIDE +: ADDR_W] =
                  pipe_addr[i];
            end
         end
         OFS_STATUS: begin
            rd_word[STAT_W-1:0] = stat_reg;
         end
         OFS_MASK: begin
            rd_word[STAT_W-1:0] = mask_reg;
         end
         default: begin
            rd_word = WORD_ZERO;
         end
      endcase
      if (!word_ok_reg) begin
         rd_word = WORD_ZERO;
      end
   end

   // The read word is captured in the wait state and then held.
   always_comb begin
      hrdata_next = rd_latch ? rd_word : hrdata_reg;
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         hrdata_reg <= WORD_ZERO;
      end else begin
         hrdata_reg <= hrdata_next;
      end
   end

   // Bus answer: stall only during a read wait state, always OKAY.
   assign hrdata_out    = hrdata_reg;
   assign hreadyout_out = (state_reg != UHFA_RD_WAIT);
   assign hresp_out     = HRESP_OKAY;

   // Outputs toward the rest of the controller.
   assign irq_out           = irq_reg;
   assign host_irq_req_out  = req_reg;
   assign sof_pulse_out     = sof_pulse;
   assign sof_count_out     = sof_count;
   assign pipe_dev_addr_out = pipe_addr;

endmodule : uhfa_regs

// ===== design/uhfa_pkg.sv
package uhfa_pkg;

   // Register byte offsets, decoded from the low address bits only.
   localparam int unsigned ADDR_DEC_W = 12;
   localparam logic [11:0] OFS_EN_VIEW   = 12'h410;
   localparam logic [11:0] OFS_EN_CLEAR  = 12'h414;
   localparam logic [11:0] OFS_EN_SET    = 12'h418;
   localparam logic [11:0] OFS_FRAME     = 12'h420;
   localparam logic [11:0] OFS_ADDR_LOW  = 12'h424;
   localparam logic [11:0] OFS_ADDR_HIGH = 12'h428;
   localparam logic [11:0] OFS_STATUS    = 12'h430;
   localparam logic [11:0] OFS_MASK      = 12'h434;

   // Enable layout: global events, pipes and DMA channels.
   localparam logic [31:0] EN_BITS_MASK = 32'h7e007f7f;
   localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

   // Frame register layout.
   localparam int unsigned SOF_COUNT_LSB = 3;
   localparam int unsigned SOF_COUNT_W   = 11;
   localparam int unsigned FLEN_LSB = 16;
   localparam int unsigned FLEN_W   = 8;
   localparam int unsigned FCNT_W   = 14;

   // Pipe address layout.
   localparam int unsigned PIPES       = 7;
   localparam int unsigned PIPES_LOW   = 4;
   localparam int unsigned ADDR_W      = 7;
   localparam int unsigned ADDR_STRIDE = 8;

   // Sticky status bits of this block.
   localparam int unsigned STAT_W        = 2;
   localparam int unsigned STAT_SOF_BIT  = 0;
   localparam int unsigned STAT_WIPE_BIT = 1;

   // Bus encodings.
   localparam int unsigned HTRANS_ACT_BIT = 1;
   localparam logic [2:0]  HSIZE_WORD     = 3'h2;
   localparam logic        HRESP_OKAY     = 1'b0;

   // Timing: system clock, bit clock and frame period.
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned BIT_HZ          = 12_000_000;
   localparam int unsigned FRAME_PERIOD_US = 1000;
   localparam int unsigned TICK_STEP       = BIT_HZ / 1_000_000;
   localparam int unsigned TICK_MOD        = CLK_HZ / 1_000_000;
   localparam int unsigned FRAME_LEN_DEF   = TICK_STEP * FRAME_PERIOD_US;
   localparam int unsigned ACC_W           = 6;

   typedef enum logic [1:0] {
      UHFA_IDLE    = 2'b00,
      UHFA_WRITE   = 2'b01,
      UHFA_RD_WAIT = 2'b11,
      UHFA_RD_DONE = 2'b10
   } uhfa_bus_state_type;

endpackage : uhfa_pkg

// ===== design/uhfa_addr_field.sv
`timescale 1ns/1ps
module uhfa_addr_field
   import uhfa_pkg::*;
(
   input  wire logic              ref_clk_in,
   input  wire logic              rst_in,
   input  wire logic              wr_en_in,
   input  wire logic [ADDR_W-1:0] wr_data_in,
   input  wire logic              wipe_in,
   output logic      [ADDR_W-1:0] addr_out
);

   logic [ADDR_W-1:0] addr_reg;
   logic [ADDR_W-1:0] addr_next;

   // A bus reset request beats a write in the same cycle.
   always_comb begin
      addr_next = addr_reg;
      if (wipe_in) begin
         addr_next = '0;
      end else if (wr_en_in) begin
         addr_next = wr_data_in;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         addr_reg <= '0;
      end else begin
         addr_reg <= addr_next;
      end
   end

   assign addr_out = addr_reg;

endmodule : uhfa_addr_field

// ===== design/uhfa_frame_timer.sv
`timescale 1ns/1ps
module uhfa_frame_timer
   import uhfa_pkg::*;
#(
   parameter int unsigned FRAME_LEN = FRAME_LEN_DEF
)(
   input  wire logic              ref_clk_in,
   input  wire logic              rst_in,
   input  wire logic              load_in,
   input  wire logic [SOF_COUNT_W-1:0] load_val_in,
   output logic      [SOF_COUNT_W-1:0] sof_count_out,
   output logic      [FCNT_W-1:0] flen_out,
   output logic                   sof_pulse_out
);

   localparam logic [FCNT_W-1:0] FLEN_LAST = FCNT_W'(FRAME_LEN - 1);
   localparam logic [ACC_W-1:0]  ACC_STEP  = ACC_W'(TICK_STEP);
   localparam logic [ACC_W-1:0]  ACC_WRAP  = ACC_W'(TICK_MOD - TICK_STEP);
   localparam logic [ACC_W-1:0]  ACC_MODV  = ACC_W'(TICK_MOD);

   logic [ACC_W-1:0]  acc_reg, acc_next;
   logic [FCNT_W-1:0] flen_reg, flen_next;
   logic [SOF_COUNT_W-1:0] sof_count_reg, sof_count_next;
   logic              sof_reg, sof_next;
   logic              tick;

   // A phase accumulator makes an exact 12 MHz average tick from the
   // 50 MHz clock; the jitter is one clock, far inside a frame.
   always_comb begin
      tick      = (acc_reg >= ACC_WRAP);
      acc_next  = tick ? (acc_reg - ACC_WRAP) : (acc_reg + ACC_STEP);
      flen_next = flen_reg;
      sof_count_next = sof_count_reg;
      sof_next  = 1'b0;
      if (tick) begin
         if (flen_reg == FLEN_LAST) begin
            flen_next = '0;
            sof_count_next = sof_count_reg + 1'b1;
            sof_next  = 1'b1;
         end else begin
            flen_next = flen_reg + 1'b1;
         end
      end
      // A software write wins over a frame boundary in the same cycle.
      if (load_in) begin
         sof_count_next = load_val_in;
      end
      if (acc_next >= ACC_MODV) begin
         acc_next = '0;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         acc_reg  <= '0;
         flen_reg <= '0;
         sof_count_reg <= '0;
         sof_reg  <= 1'b0;
      end else begin
         acc_reg  <= acc_next;
         flen_reg <= flen_next;
         sof_count_reg <= sof_count_next;
         sof_reg  <= sof_next;
      end
   end

   assign sof_count_out = sof_count_reg;
   assign flen_out      = flen_reg;
   assign sof_pulse_out = sof_reg;

endmodule : uhfa_frame_timer

// ===== sim/uhfa_regs_props.sv
`timescale 1ns/1ps
module uhfa_regs_props
   import uhfa_pkg::*;
#(
   parameter int unsigned FRAME_LEN = FRAME_LEN_DEF
)(
   input wire logic                         ref_clk_in,
   input wire logic                         rst_in,
   input wire logic                         hsel_in,
   input wire logic [31:0]                  haddr_in,
   input wire logic [1:0]                   htrans_in,
   input wire logic                         hwrite_in,
   input wire logic                         hready_in,
   input wire logic [31:0]                  hrdata_out,
   input wire logic                         hreadyout_out,
   input wire logic [31:0]                  irq_flags_in,
   input wire logic                         usb_reset_req_in,
   input wire logic                         irq_out,
   input wire logic                         host_irq_req_out,
   input wire logic                         sof_pulse_out,
   input wire logic [PIPES-1:0][ADDR_W-1:0] pipe_dev_addr_out
);
   // Frame spacing may wobble by one clock.
   localparam int GAP_LO = FRAME_LEN * TICK_MOD / TICK_STEP - 1;
   localparam int GAP_HI = GAP_LO + 2;
   logic        take;
   logic        rd_take;
   logic [11:0] ofs;
   logic [15:0] gap_reg;
   logic [15:0] gap_next;

   // Transfer decode as the slave sees it.
   assign take    = hsel_in & hready_in & htrans_in[HTRANS_ACT_BIT];
   assign rd_take = take & ~hwrite_in;
   assign ofs     = haddr_in[11:0];

   // Clocks since the last frame start.
   always_comb begin
      gap_next = sof_pulse_out ? 16'h0001 : gap_reg + 16'h0001;
   end
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) gap_reg <= 16'h0000;
      else gap_reg <= gap_next;
   end

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);

   property p_rd_zero(logic [11:0] o, logic [31:0] m);
      rd_take && ofs == o |=> ##1 (hrdata_out & m) == WORD_ZERO;
   endproperty

   a_write_no_wait: assert property (take && hwrite_in |=> hreadyout_out)
      else $error("write data phase stalled");
   a_read_one_wait: assert property (
      rd_take |=> !hreadyout_out ##1 hreadyout_out)
      else $error("read wait state wrong");
   a_set_reads_zero: assert property (
      p_rd_zero(OFS_EN_SET, 32'hffff_ffff))
      else $error("set port read not zero");
   a_clr_reads_zero: assert property (
      p_rd_zero(OFS_EN_CLEAR, 32'hffff_ffff))
      else $error("clear port read not zero");
   a_view_bits_only: assert property (
      p_rd_zero(OFS_EN_VIEW, ~EN_BITS_MASK))
      else $error("enable view shows stray bits");
   a_frame_pads_zero: assert property (
      p_rd_zero(OFS_FRAME, 32'hff00_c007))
      else $error("frame register pads not zero");
   a_addr_low_pads: assert property (
      p_rd_zero(OFS_ADDR_LOW, 32'h8080_8080))
      else $error("low address pads not zero");
   a_addr_high_top: assert property (
      p_rd_zero(OFS_ADDR_HIGH, 32'hff80_8080))
      else $error("high address top byte not zero");
   a_bus_reset_wipe: assert property (
      usb_reset_req_in |=> pipe_dev_addr_out == '0)
      else $error("pipe address survived bus reset");
   a_sof_single: assert property (sof_pulse_out |=> !sof_pulse_out)
      else $error("frame start pulse too long");
   a_sof_spacing: assert property (
      sof_pulse_out |-> gap_reg >= GAP_LO && gap_reg <= GAP_HI)
      else $error("frame period wrong");
   a_irq_req_quiet: assert property (
      irq_flags_in == WORD_ZERO |=> !host_irq_req_out)
      else $error("request without any flag");

   c_read: cover property (rd_take);
   c_sof: cover property (sof_pulse_out);
   c_wipe: cover property (usb_reset_req_in);
   c_irq: cover property ($rose(irq_out));
endmodule : uhfa_regs_props

bind uhfa_regs uhfa_regs_props #(.FRAME_LEN(FRAME_LEN)) u_props (
   .ref_clk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
   .hready_in, .hrdata_out, .hreadyout_out, .irq_flags_in,
   .usb_reset_req_in, .irq_out, .host_irq_req_out, .sof_pulse_out,
   .pipe_dev_addr_out);

// ===== sim/uhfa_usb_dev.sv
`timescale 1ns/1ps
module uhfa_usb_dev
   import uhfa_pkg::*;
(
   input  wire logic              ref_clk_in,
   input  wire logic              rst_in,
   input  wire logic              sof_pulse_in,
   input  wire logic [SOF_COUNT_W-1:0] sof_count_in,
   input  wire logic [31:0]       flags_cmd_in,
   input  wire logic              bus_reset_cmd_in,
   output logic      [31:0]       irq_flags_out,
   output logic                   usb_reset_req_out,
   output logic      [SOF_COUNT_W-1:0] last_frame_out
);
   // Flags and reset requests come from registers, so they move on edges.
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_flags_out     <= WORD_ZERO;
         usb_reset_req_out <= 1'b0;
         last_frame_out    <= '0;
      end else begin
         irq_flags_out     <= flags_cmd_in;
         usb_reset_req_out <= bus_reset_cmd_in;
         if (sof_pulse_in) last_frame_out <= sof_count_in;
      end
   end
endmodule : uhfa_usb_dev

// ===== sim/uhfa_regs_tb.sv
`timescale 1ns/1ps
module uhfa_regs_tb
   import uhfa_pkg::*;
;
   // Short frames keep the run brief; only the bound frame spacing check derives from FL.
   localparam int unsigned FL = 600;
   logic                         ref_clk_in;
   logic                         rst_in;
   logic                         hsel_in;
   logic [31:0]                  haddr_in;
   logic [1:0]                   htrans_in;
   logic                         hwrite_in;
   logic [2:0]                   hsize_in;
   logic [31:0]                  hwdata_in;
   logic [31:0]                  hrdata_out;
   logic                         hreadyout_out;
   logic                         hresp_out;
   logic [31:0]                  irq_flags_in;
   logic                         usb_reset_req_in;
   logic                         irq_out;
   logic                         host_irq_req_out;
   logic                         sof_pulse_out;
   logic [SOF_COUNT_W-1:0]            sof_count_out;
   logic [PIPES-1:0][ADDR_W-1:0] pipe_dev_addr_out;
   logic [31:0]                  flags_cmd;
   logic                         brst_cmd;
   logic [SOF_COUNT_W-1:0]            last_frame;
   int                           fails;
   int                           total_checks;

   uhfa_regs #(.FRAME_LEN(FL)) DUT (
      .ref_clk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
      .hsize_in, .hwdata_in, .hready_in(hreadyout_out), .hrdata_out,
      .hreadyout_out, .hresp_out, .irq_flags_in, .usb_reset_req_in,
      .irq_out, .host_irq_req_out, .sof_pulse_out, .sof_count_out,
      .pipe_dev_addr_out);

   uhfa_usb_dev PARTNER (
      .ref_clk_in, .rst_in, .sof_pulse_in(sof_pulse_out),
      .sof_count_in(sof_count_out), .flags_cmd_in(flags_cmd),
      .bus_reset_cmd_in(brst_cmd), .irq_flags_out(irq_flags_in),
      .usb_reset_req_out(usb_reset_req_in), .last_frame_out(last_frame));

   // Free running 50 MHz clock.
   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end

   task automatic cycles(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask : cycles

   task automatic end_of_test();
      if (fails == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One single word transfer; the data phase ends when ready is sampled.
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
      hsel_in   <= 1'b1;
      haddr_in  <= {20'h00000, a};
      htrans_in <= 2'h2;
      hwrite_in <= w;
      do @(posedge ref_clk_in); while (hreadyout_out !== 1'b1);
      hsel_in   <= 1'b0;
      htrans_in <= 2'h0;
      hwdata_in <= wd;
      do @(posedge ref_clk_in); while (hreadyout_out !== 1'b1);
      rd = hrdata_out;
   endtask : xfer

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      xfer(1'b1, a, d, x);
   endtask : wr

   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] x;
      xfer(1'b0, a, WORD_ZERO, x);
      chk(x, e);
      chk(32'(hresp_out), 32'(HRESP_OKAY));
   endtask : rdchk

   task automatic wait_sof();
      int n;
      n = 0;
      do begin
         @(posedge ref_clk_in);
         n++;
      end while (sof_pulse_out !== 1'b1 && n < 3000);
      chk(32'(sof_pulse_out), 32'h1);
      cycles(1);
   endtask : wait_sof

   task automatic t_reset_vals();
      logic [11:0] o[6] = '{OFS_EN_VIEW, OFS_EN_SET, OFS_EN_CLEAR,
                            OFS_ADDR_LOW, OFS_ADDR_HIGH, 12'h500};
      foreach (o[i]) rdchk(o[i], WORD_ZERO);
   endtask : t_reset_vals

   // Walk every bit through the set port, then through the clear port.
   task automatic t_enables();
      logic [31:0] acc;
      acc = WORD_ZERO;
      for (int i = 0; i < 32; i++) begin
         wr(OFS_EN_SET, 32'h1 << i);
         wr(OFS_EN_CLEAR, WORD_ZERO);
         acc = acc | (EN_BITS_MASK & (32'h1 << i));
         rdchk(OFS_EN_VIEW, acc);
      end
      wr(OFS_EN_VIEW, WORD_ZERO);
      rdchk(OFS_EN_VIEW, EN_BITS_MASK);
      for (int i = 0; i < 32; i++) begin
         wr(OFS_EN_CLEAR, 32'h1 << i);
         wr(OFS_EN_SET, WORD_ZERO);
         acc = acc & ~(32'h1 << i);
         rdchk(OFS_EN_VIEW, acc);
      end
   endtask : t_enables

   task automatic t_irq_req();
      flags_cmd <= 32'h0000_0200;
      cycles(4);
      chk(32'(host_irq_req_out), 32'h0);
      wr(OFS_EN_SET, 32'hffff_ffff);
      cycles(3);
      chk(32'(host_irq_req_out), 32'h1);
      wr(OFS_EN_CLEAR, 32'h0000_0200);
      cycles(3);
      chk(32'(host_irq_req_out), 32'h0);
      flags_cmd <= 32'h0200_0000;
      cycles(4);
      chk(32'(host_irq_req_out), 32'h1);
      flags_cmd <= WORD_ZERO;
   endtask : t_irq_req

   task automatic t_addr();
      wr(OFS_ADDR_LOW, 32'hffff_ffff);
      rdchk(OFS_ADDR_LOW, 32'h7f7f_7f7f);
      wr(OFS_ADDR_HIGH, 32'hffff_ffff);
      rdchk(OFS_ADDR_HIGH, 32'h007f_7f7f);
      wr(OFS_ADDR_LOW, 32'h0122_4364);
      rdchk(OFS_ADDR_LOW, 32'h0122_4364);
      chk(32'(pipe_dev_addr_out[3]), 32'h01);
      chk(32'(pipe_dev_addr_out[6]), 32'h7f);
      brst_cmd <= 1'b1;
      cycles(3);
      brst_cmd <= 1'b0;
      rdchk(OFS_ADDR_LOW, WORD_ZERO);
      rdchk(OFS_ADDR_HIGH, WORD_ZERO);
   endtask : t_addr

   // Load a number just short of the 11-bit wrap and follow the frames.
   task automatic t_frame();
      logic [31:0] x;
      wait_sof();
      wr(OFS_FRAME, 32'hffff_3ff0);
      rdchk(OFS_FRAME, 32'h0000_3ff0);
      wait_sof();
      chk(32'(last_frame), 32'h7ff);
      wait_sof();
      chk(32'(last_frame), 32'h000);
      cycles(1250);
      xfer(1'b0, OFS_FRAME, WORD_ZERO, x);
      chk(32'(x[23:16]), ((1250 * TICK_STEP) / TICK_MOD) >> 6);
   endtask : t_frame

   task automatic t_status();
      wait_sof();
      cycles(3);
      chk(32'(irq_out), 32'h0);
      wr(OFS_MASK, 32'hffff_fffd);
      rdchk(OFS_MASK, 32'h0000_0001);
      chk(32'(irq_out), 32'h1);
      rdchk(OFS_STATUS, 32'h0000_0003);
      cycles(2);
      chk(32'(irq_out), 32'h0);
      rdchk(OFS_STATUS, WORD_ZERO);
      wr(OFS_MASK, 32'h0000_0002);
      wait_sof();
      cycles(3);
      chk(32'(irq_out), 32'h0);
      brst_cmd <= 1'b1;
      cycles(1);
      brst_cmd <= 1'b0;
      cycles(4);
      chk(32'(irq_out), 32'h1);
      rdchk(OFS_STATUS, 32'h0000_0003);
   endtask : t_status

   // Ends a hung run well after the tests should finish.
   initial begin
      cycles(40000);
      fails++;
      end_of_test();
   end

   initial begin
      fails = 0;
      total_checks = 0;
      rst_in = 1'b1;
      hsel_in = 1'b0;
      haddr_in = WORD_ZERO;
      htrans_in = 2'h0;
      hwrite_in = 1'b0;
      hsize_in = HSIZE_WORD;
      hwdata_in = WORD_ZERO;
      flags_cmd = WORD_ZERO;
      brst_cmd = 1'b0;
      cycles(8);
      rst_in <= 1'b0;
      @(posedge ref_clk_in);
      t_reset_vals();
      t_enables();
      t_irq_req();
      t_addr();
      t_frame();
      t_status();
      end_of_test();
   end
endmodule : uhfa_regs_tb
